// ### pkg/psp_pkg.sv
// constants shared by the peripheral serial port design
`default_nettype none
package psp_pkg;
   localparam int unsigned PSP_CLK_PERIOD_NS  = 8;
   localparam int unsigned PSP_CLK_HZ         = 1_000_000_000 / PSP_CLK_PERIOD_NS;
   localparam int unsigned PSP_NUM_RATES      = 8;
   localparam int unsigned PSP_BAUD [0:7]     = '{300, 1200, 2400, 4800, 9600, 19_200, 38_400, 115_200};
   localparam int unsigned PSP_DIV_W          = 20;
   localparam int unsigned PSP_DATA_BITS      = 8;
   localparam int unsigned PSP_FRAME_BITS     = 10;
   localparam logic [9:0]  PSP_SHIFT_RESET    = 10'h3ff;
   localparam int unsigned PSP_RING_FILT_NS   = 1000;
   localparam int unsigned PSP_RING_FILT_CYC  = (PSP_RING_FILT_NS + PSP_CLK_PERIOD_NS - 1) / PSP_CLK_PERIOD_NS;
   localparam int unsigned PSP_SD_HALF_NS     = 1000;
   localparam int unsigned PSP_SD_HALF_CYC    = (PSP_SD_HALF_NS + PSP_CLK_PERIOD_NS - 1) / PSP_CLK_PERIOD_NS;
   localparam int unsigned PSP_CNT_W          = 8;
   localparam logic        PSP_TXD_IDLE       = 1'b0;
   localparam logic        PSP_RS232_IDLE     = 1'b1;

   typedef enum logic [4:0]
   {
      PSP_SD_IDLE  = 5'h01,
      PSP_SD_SETUP = 5'h02,
      PSP_SD_LOW   = 5'h04,
      PSP_SD_HIGH  = 5'h08,
      PSP_SD_DONE  = 5'h10
   } psp_sd_state_e;
endpackage : psp_pkg
`default_nettype wire

// ### pkg/psp_byte_if.sv
// byte stream carrier between the port top and its serialisers
`default_nettype none
interface psp_byte_if;
   logic [7:0] data;
   logic       valid;
   logic       ready;
   logic       busy;
   logic       err;
   modport src (output data, output valid, input ready, input busy, output err);
   modport snk (input data, input valid, output ready, output busy, input err);
endinterface : psp_byte_if
`default_nettype wire

// ### design/psp_uart_tx.sv
// asynchronous 8n1 serialiser with start gating
`default_nettype none
module psp_uart_tx
   import psp_pkg::*;
#(
   parameter logic INVERT = 1'b0
)
(
   input  wire logic                 core_clk_i,
   input  wire logic                 resetn_i,
   input  wire logic [PSP_DIV_W-1:0] div_i,
   input  wire logic                 allow_i,
   psp_byte_if.snk                   s,
   output logic                      line_o
);
   logic [9:0]           shreg;
   logic                 busy;
   logic [PSP_DIV_W-1:0] cnt;
   logic [3:0]           bits;

   assign s.ready = ~busy & allow_i;
   assign s.busy  = busy;

   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         busy  <= 1'b0;
         shreg <= PSP_SHIFT_RESET;
         cnt   <= '0;
         bits  <= '0;
      end
      else if (!busy)
      begin
         if (s.valid && allow_i)
         begin
            shreg <= {1'b1, s.data, 1'b0};
            busy  <= 1'b1;
            cnt   <= div_i - 1'b1;
            bits  <= '0;
         end
      end
      else if (cnt == '0)
      begin
         shreg <= {1'b1, shreg[9:1]};
         cnt   <= div_i - 1'b1;
         if (bits == 4'(PSP_FRAME_BITS - 1))
            busy <= 1'b0;
         else
            bits <= bits + 1'b1;
      end
      else
         cnt <= cnt - 1'b1;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
         line_o <= ~INVERT;
      else
         line_o <= shreg[0] ^ INVERT;
   end
endmodule : psp_uart_tx
`default_nettype wire

// ### design/psp_uart_rx.sv
// asynchronous 8n1 receiver with mid-bit sampling
`default_nettype none
module psp_uart_rx
   import psp_pkg::*;
#(
   parameter logic INVERT = 1'b0
)
(
   input  wire logic                 core_clk_i,
   input  wire logic                 resetn_i,
   input  wire logic [PSP_DIV_W-1:0] div_i,
   input  wire logic                 line_i,
   psp_byte_if.src                   m
);
   logic                 norm;
   logic                 active;
   logic [PSP_DIV_W-1:0] cnt;
   logic [3:0]           bits;
   logic [7:0]           shreg;

   assign norm = line_i ^ INVERT;

   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         active  <= 1'b0;
         cnt     <= '0;
         bits    <= '0;
         shreg   <= '0;
         m.data  <= '0;
         m.valid <= 1'b0;
         m.err   <= 1'b0;
      end
      else
      begin
         m.valid <= 1'b0;
         if (!active)
         begin
            if (!norm)
            begin
               active <= 1'b1;
               cnt    <= {1'b0, div_i[PSP_DIV_W-1:1]};
               bits   <= '0;
            end
         end
         else if (cnt != '0)
            cnt <= cnt - 1'b1;
         else
         begin
            cnt  <= div_i - 1'b1;
            bits <= bits + 1'b1;
            if (bits == 4'd0)
               active <= ~norm;
            else if (bits <= 4'(PSP_DATA_BITS))
               shreg <= {norm, shreg[7:1]};
            else
            begin
               active  <= 1'b0;
               m.data  <= shreg;
               m.valid <= 1'b1;
               m.err   <= ~norm;
            end
         end
      end
   end
endmodule : psp_uart_rx
`default_nettype wire

// ### design/psp_serial_port.sv
// peripheral serial connector and isolated rs-232 port logic
//
// Behaviour
// - incoming call switches device to telecom mode
// - confirmed modem ring raises modem wake output
// - select output addresses synchronous peripherals
// - select output doubles as printer enable
// - clock line, select and txd move sync data
// - handshake high permits, low blocks printer output; low only holds back the next character, one already started finishes
// - txd idles low, spacing high, inverted
// - frame: start, eight data, no parity, stop
// - eight selectable bit rates, 300 to 115200
// - receive line uses same framing and rate
// - rs-232 port: dtr, tx, rts out; rx, cts, ring in
`default_nettype none
module psp_serial_port
   import psp_pkg::*;
#(
   parameter int unsigned CLK_FREQ_HZ = PSP_CLK_HZ
)
(
   input  wire logic       core_clk_i,
   input  wire logic       resetn_i,
   input  wire logic [2:0] baud_sel_i,
   input  wire logic       printer_mode_i,
   input  wire logic       telecom_end_i,
   input  wire logic [7:0] tx_data_i,
   input  wire logic       tx_valid_i,
   output logic            tx_ready_o,
   output logic [7:0]      rx_data_o,
   output logic            rx_valid_o,
   output logic            rx_frame_err_o,
   input  wire logic [7:0] sd_data_i,
   input  wire logic       sd_start_i,
   output logic            sd_busy_o,
   output logic            telecom_mode_o,
   input  wire logic       ring_i,
   input  wire logic       rxd_i,
   output logic            txd_o,
   output logic            modem_wake_out_o,
   output logic            sync_device_select_o,
   input  wire logic       sync_clock_or_handshake_i,
   output logic            sync_clock_or_handshake_o,
   output logic            sync_clock_or_handshake_oe_o,
   input  wire logic       rs232_enable_i,
   input  wire logic [7:0] rs232_tx_data_i,
   input  wire logic       rs232_tx_valid_i,
   output logic            rs232_tx_ready_o,
   output logic [7:0]      rs232_rx_data_o,
   output logic            rs232_rx_valid_o,
   output logic            rs232_rx_frame_err_o,
   output logic            rs232_dtr_o,
   output logic            rs232_tx_o,
   output logic            rs232_rts_o,
   input  wire logic       rs232_rx_i,
   input  wire logic       rs232_cts_i,
   input  wire logic       rs232_ring_i
);
   function automatic logic [PSP_DIV_W-1:0] baud_div(input logic [2:0] sel);
      baud_div = PSP_DIV_W'(CLK_FREQ_HZ / PSP_BAUD[sel]);
   endfunction : baud_div

   psp_byte_if cs_tx ();
   psp_byte_if cs_rx ();
   psp_byte_if pc_tx ();
   psp_byte_if pc_rx ();

   logic [PSP_DIV_W-1:0] div;
   logic                 cs_line;
   logic                 pc_line;
   logic                 cs_allow;
   logic                 pc_allow;
   logic [7:0]           cs_hold;
   logic                 cs_pend;
   logic [7:0]           pc_hold;
   logic                 pc_pend;
   logic [PSP_CNT_W-1:0] ring_cnt;
   logic                 ring_ok;
   psp_sd_state_e        sd_state;
   psp_sd_state_e        next_sd_state;
   logic [PSP_CNT_W-1:0] sd_cnt;
   logic [2:0]           sd_bit;
   logic [7:0]           sd_shreg;
   logic                 sd_active;

   // one rate for both ports
   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
         div <= baud_div(3'h0);
      else
         div <= baud_div(baud_sel_i);
   end

   assign sd_active = (sd_state != PSP_SD_IDLE);

   // printer handshake only gates the start of a character
   assign cs_allow = ~sd_active & ~sd_start_i
                     & (~printer_mode_i | sync_clock_or_handshake_i);
   assign pc_allow = rs232_cts_i;

   assign cs_tx.data  = cs_hold;
   assign cs_tx.valid = cs_pend;
   assign cs_tx.err   = 1'b0;
   assign pc_tx.data  = pc_hold;
   assign pc_tx.valid = pc_pend;
   assign pc_tx.err   = 1'b0;
   assign cs_rx.ready = 1'b1;
   assign pc_rx.ready = 1'b1;

   psp_uart_tx #(.INVERT(1'b1)) u_cs_tx
   (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .div_i      (div),
      .allow_i    (cs_allow),
      .s          (cs_tx),
      .line_o     (cs_line)
   );

   psp_uart_rx #(.INVERT(1'b1)) u_cs_rx
   (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .div_i      (div),
      .line_i     (rxd_i),
      .m          (cs_rx)
   );

   psp_uart_tx #(.INVERT(1'b0)) u_pc_tx
   (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .div_i      (div),
      .allow_i    (pc_allow),
      .s          (pc_tx),
      .line_o     (pc_line)
   );

   psp_uart_rx #(.INVERT(1'b0)) u_pc_rx
   (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .div_i      (div),
      .line_i     (rs232_rx_i),
      .m          (pc_rx)
   );

   // one-entry holding stage for the connector transmitter
   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         cs_hold    <= '0;
         cs_pend    <= 1'b0;
         tx_ready_o <= 1'b0;
      end
      else if (tx_valid_i && tx_ready_o)
      begin
         cs_hold    <= tx_data_i;
         cs_pend    <= 1'b1;
         tx_ready_o <= 1'b0;
      end
      else if (cs_pend && cs_tx.ready)
      begin
         cs_pend    <= 1'b0;
         tx_ready_o <= 1'b1;
      end
      else
         tx_ready_o <= ~cs_pend;
   end

   // one-entry holding stage for the rs-232 transmitter
   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         pc_hold          <= '0;
         pc_pend          <= 1'b0;
         rs232_tx_ready_o <= 1'b0;
      end
      else if (rs232_tx_valid_i && rs232_tx_ready_o)
      begin
         pc_hold          <= rs232_tx_data_i;
         pc_pend          <= 1'b1;
         rs232_tx_ready_o <= 1'b0;
      end
      else if (pc_pend && pc_tx.ready)
      begin
         pc_pend          <= 1'b0;
         rs232_tx_ready_o <= 1'b1;
      end
      else
         rs232_tx_ready_o <= ~pc_pend;
   end

   // rs-232 modem-side control lines
   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         rs232_dtr_o <= 1'b0;
         rs232_rts_o <= 1'b0;
         rs232_tx_o  <= PSP_RS232_IDLE;
      end
      else
      begin
         rs232_dtr_o <= rs232_enable_i;
         rs232_rts_o <= rs232_enable_i & (pc_pend | pc_tx.busy);
         rs232_tx_o  <= pc_line;
      end
   end

   // received characters to the user side
   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         rx_data_o            <= '0;
         rx_valid_o           <= 1'b0;
         rx_frame_err_o       <= 1'b0;
         rs232_rx_data_o      <= '0;
         rs232_rx_valid_o     <= 1'b0;
         rs232_rx_frame_err_o <= 1'b0;
      end
      else
      begin
         rx_data_o            <= cs_rx.data;
         rx_valid_o           <= cs_rx.valid;
         rx_frame_err_o       <= cs_rx.valid & cs_rx.err;
         rs232_rx_data_o      <= pc_rx.data;
         rs232_rx_valid_o     <= pc_rx.valid;
         rs232_rx_frame_err_o <= pc_rx.valid & pc_rx.err;
      end
   end

   // ring must hold steady before it counts as a call
   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         ring_cnt <= '0;
         ring_ok  <= 1'b0;
      end
      else if (!ring_i)
      begin
         ring_cnt <= '0;
         ring_ok  <= 1'b0;
      end
      else if (ring_cnt == PSP_CNT_W'(PSP_RING_FILT_CYC - 1))
         ring_ok <= 1'b1;
      else
         ring_cnt <= ring_cnt + 1'b1;
   end

   // telecom mode; a new call wins over the end request
   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         telecom_mode_o   <= 1'b0;
         modem_wake_out_o <= 1'b0;
      end
      else if (ring_ok || rs232_ring_i)
      begin
         telecom_mode_o <= 1'b1;
         if (ring_ok)
            modem_wake_out_o <= 1'b1;
      end
      else if (telecom_end_i)
      begin
         telecom_mode_o   <= 1'b0;
         modem_wake_out_o <= 1'b0;
      end
   end

   // synchronous device transfer sequencer
   always_comb
   begin
      next_sd_state = sd_state;
      unique case (sd_state)
         PSP_SD_IDLE:
            if (sd_start_i && !cs_tx.busy)
               next_sd_state = PSP_SD_SETUP;
         PSP_SD_SETUP:
            if (sd_cnt == '0)
               next_sd_state = PSP_SD_LOW;
         PSP_SD_LOW:
            if (sd_cnt == '0)
               next_sd_state = PSP_SD_HIGH;
         PSP_SD_HIGH:
            if (sd_cnt == '0)
               next_sd_state = (sd_bit == 3'h7) ? PSP_SD_DONE : PSP_SD_LOW;
         PSP_SD_DONE:
            if (sd_cnt == '0)
               next_sd_state = PSP_SD_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
         sd_state <= PSP_SD_IDLE;
      else
         sd_state <= next_sd_state;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         sd_cnt   <= '0;
         sd_bit   <= '0;
         sd_shreg <= '0;
      end
      else if (sd_state == PSP_SD_IDLE)
      begin
         sd_cnt <= PSP_CNT_W'(PSP_SD_HALF_CYC - 1);
         sd_bit <= '0;
         if (next_sd_state == PSP_SD_SETUP)
            sd_shreg <= sd_data_i;
      end
      else if (sd_cnt != '0)
         sd_cnt <= sd_cnt - 1'b1;
      else
      begin
         sd_cnt <= PSP_CNT_W'(PSP_SD_HALF_CYC - 1);
         if (sd_state == PSP_SD_HIGH)
         begin
            sd_bit   <= sd_bit + 1'b1;
            sd_shreg <= {1'b0, sd_shreg[7:1]};
         end
      end
   end

   // connector pins: select, clock and shared transmit line
   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         sd_busy_o                    <= 1'b0;
         sync_device_select_o         <= 1'b0;
         sync_clock_or_handshake_o    <= 1'b0;
         sync_clock_or_handshake_oe_o <= 1'b0;
         txd_o                        <= PSP_TXD_IDLE;
      end
      else
      begin
         sd_busy_o                    <= (next_sd_state != PSP_SD_IDLE);
         sync_device_select_o         <= (next_sd_state != PSP_SD_IDLE)
                                         | printer_mode_i;
         sync_clock_or_handshake_o    <= (next_sd_state == PSP_SD_HIGH);
         sync_clock_or_handshake_oe_o <= (next_sd_state != PSP_SD_IDLE);
         if (sd_active)
            txd_o <= (sd_state == PSP_SD_LOW || sd_state == PSP_SD_HIGH) ? sd_shreg[0] : PSP_TXD_IDLE;
         else
            txd_o <= cs_line;
      end
   end
endmodule : psp_serial_port
`default_nettype wire

// ### test/psp_serial_port_chk.sv
// pin assertions for the peripheral serial port
`default_nettype none
module psp_serial_port_chk
(
   input  wire logic core_clk_i,
   input  wire logic resetn_i,
   input  wire logic printer_mode_i,
   input  wire logic tx_valid_i,
   input  wire logic tx_ready_o,
   input  wire logic rx_valid_o,
   input  wire logic rx_frame_err_o,
   input  wire logic sd_busy_o,
   input  wire logic telecom_mode_o,
   input  wire logic ring_i,
   input  wire logic txd_o,
   input  wire logic modem_wake_out_o,
   input  wire logic sync_device_select_o,
   input  wire logic sync_clock_or_handshake_oe_o,
   input  wire logic rs232_enable_i,
   input  wire logic rs232_dtr_o,
   input  wire logic rs232_ring_i,
   input  wire logic rs232_tx_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ring_run;

   // consecutive cycles of incoming call
   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i || !ring_i)
         ring_run <= 8'h00;
      else if (ring_run != 8'hff)
         ring_run <= ring_run + 8'h01;
   end

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!resetn_i);

   a_idle_after_reset: assert property ($rose(resetn_i) |-> !txd_o && rs232_tx_o)
      else $error("serial lines not idle after reset");
   a_ring_wakes: assert property (ring_run == 8'h7d |-> ##[1:3] modem_wake_out_o)
      else $error("modem wake missing after ring");
   a_wake_filtered: assert property ($rose(modem_wake_out_o) |-> $past(ring_run, 4) >= 8'h78)
      else $error("modem wake without long ring");
   a_wake_in_mode: assert property (modem_wake_out_o |-> telecom_mode_o)
      else $error("wake outside telecom mode");
   a_alt_ring_mode: assert property (rs232_ring_i |=> telecom_mode_o)
      else $error("rs232 ring did not set mode");
   a_printer_select: assert property (printer_mode_i |=> sync_device_select_o)
      else $error("select low in printer mode");
   a_busy_selects: assert property (sd_busy_o |-> sync_device_select_o)
      else $error("sync transfer without select");
   a_clock_in_sync: assert property (sync_clock_or_handshake_oe_o |-> sd_busy_o)
      else $error("clock pin driven outside sync transfer");
   a_err_with_valid: assert property (rx_frame_err_o |-> rx_valid_o)
      else $error("framing error without valid");
   a_rx_one_pulse: assert property (rx_valid_o |=> !rx_valid_o [*8])
      else $error("receive valid too long");
   a_take_drops_ready: assert property (tx_valid_i && tx_ready_o |=> !tx_ready_o)
      else $error("ready stayed high after take");
   a_dtr_follows: assert property ($rose(rs232_enable_i) |=> rs232_dtr_o)
      else $error("dtr not raised");

   c_frame_err: cover property (rx_frame_err_o);
   c_sync_end: cover property (sd_busy_o ##1 !sd_busy_o);
   c_wake: cover property ($rose(modem_wake_out_o));
endmodule : psp_serial_port_chk

bind psp_serial_port psp_serial_port_chk u_psp_serial_port_chk (.*);
`default_nettype wire

// ### test/psp_peer.sv
// far-side peer: serial sender, frame decoder, printer handshake
`default_nettype none
module psp_peer
   import psp_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic [19:0] div_i,
   input  wire logic        txd_i,
   input  wire logic        tx232_i,
   output logic             rxd_o,
   output logic             rx232_o,
   output logic             hs_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      rxd_o = PSP_TXD_IDLE;
      rx232_o = PSP_RS232_IDLE;
      hs_o = 1'b1;
   end

   task automatic hs(input logic v);
      hs_o = v;
   endtask : hs

   // ps high selects the rs-232 line, else the inverted connector line
   task automatic put(input bit ps, input logic [7:0] d, input bit bad);
      logic [9:0] f;
      f = {~bad, d, 1'b0};
      @(posedge core_clk_i);
      #1;
      for (int i = 0; i < 10; i++)
      begin
         if (ps)
            rx232_o = f[i];
         else
            rxd_o = ~f[i];
         repeat (div_i) @(posedge core_clk_i);
         #1;
      end
      rxd_o = PSP_TXD_IDLE;
      rx232_o = PSP_RS232_IDLE;
   endtask : put

   task automatic get(input bit ps, output logic [7:0] d, output bit ok);
      ok = 1'b0;
      d = 8'h00;
      for (int n = 0; n < 30 * div_i && !ok; n++)
      begin
         @(negedge core_clk_i);
         ok = ps ? tx232_i === 1'b0 : txd_i === 1'b1;
      end
      if (ok)
      begin
         repeat (div_i / 2) @(negedge core_clk_i);
         for (int i = 0; i < 8; i++)
         begin
            repeat (div_i) @(negedge core_clk_i);
            d[i] = ps ? tx232_i : ~txd_i;
         end
         repeat (div_i) @(negedge core_clk_i);
         ok = ps ? tx232_i === 1'b1 : txd_i === 1'b0;
      end
      @(posedge core_clk_i);
      #1;
   endtask : get
endmodule : psp_peer
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the peripheral serial port
`default_nettype none
module tb_top
   import psp_pkg::*;
   ();
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned FHZ = 500_000;
   logic        core_clk_i = 1'b0, resetn_i = 1'b0, printer_mode_i = 1'b0, telecom_end_i = 1'b0;
   logic [2:0]  baud_sel_i = 3'h7;
   logic [7:0]  tx_data_i = 8'h00, sd_data_i = 8'h00, rs232_tx_data_i = 8'h00, rx_data_o, rs232_rx_data_o;
   logic        tx_valid_i = 1'b0, sd_start_i = 1'b0, ring_i = 1'b0, rs232_enable_i = 1'b0;
   logic        rs232_tx_valid_i = 1'b0, rs232_cts_i = 1'b1, rs232_ring_i = 1'b0, rxd_i, rs232_rx_i, hs_lvl;
   logic        tx_ready_o, rx_valid_o, rx_frame_err_o, sd_busy_o, telecom_mode_o, txd_o, modem_wake_out_o;
   logic        sync_device_select_o, sync_clock_or_handshake_o, sync_clock_or_handshake_oe_o;
   logic        rs232_tx_ready_o, rs232_rx_valid_o, rs232_rx_frame_err_o, rs232_dtr_o, rs232_tx_o, rs232_rts_o;
   wire logic   sync_clock_or_handshake_i;
   logic [19:0] div = 20'h4;
   logic [7:0]  got, rgot;
   logic        gerr;
   int          fails = 0, total_checks = 0;

   assign sync_clock_or_handshake_i = sync_clock_or_handshake_oe_o ? sync_clock_or_handshake_o : hs_lvl;

   psp_serial_port #(.CLK_FREQ_HZ(FHZ)) u_psp_serial_port (.*);

   psp_peer u_psp_peer
   (
      .core_clk_i (core_clk_i),
      .div_i      (div),
      .txd_i      (txd_o),
      .tx232_i    (rs232_tx_o),
      .rxd_o      (rxd_i),
      .rx232_o    (rs232_rx_i),
      .hs_o       (hs_lvl)
   );

   always #4 core_clk_i = ~core_clk_i;

   always @(negedge core_clk_i)
   begin
      if (rx_valid_o === 1'b1)
      begin
         got = rx_data_o;
         gerr = rx_frame_err_o;
      end
      if (rs232_rx_valid_o === 1'b1)
         rgot = rs232_rx_data_o;
   end

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      total_checks++;
      if (s !== e)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : tick

   task automatic send(input bit ps, input logic [7:0] d);
      int n;
      n = 0;
      if (ps)
         {rs232_tx_valid_i, rs232_tx_data_i} = {1'b1, d};
      else
         {tx_valid_i, tx_data_i} = {1'b1, d};
      do
      begin
         @(posedge core_clk_i);
         n++;
      end
      while ((ps ? rs232_tx_ready_o : tx_ready_o) !== 1'b1 && n < 40);
      #1;
      tx_valid_i = 1'b0;
      rs232_tx_valid_i = 1'b0;
      chk("byte taken", 8'h1, 8'(n < 40));
   endtask : send

   task automatic t_rates;
      logic [7:0] d, b;
      bit ok;
      for (int s = 0; s < 8; s++)
      begin
         baud_sel_i = 3'(s);
         div = 20'(FHZ / PSP_BAUD[s]);
         b = 8'h3c + 8'(s * 37);
         tick(3);
         fork
            send(1'b0, b);
            u_psp_peer.get(1'b0, d, ok);
            u_psp_peer.put(1'b0, ~b, 1'b0);
         join
         tick(2);
         chk("txd byte", b, d);
         chk("txd stop", 8'h1, 8'(ok));
         chk("rx byte", ~b, got);
         chk("rx err", 8'h0, 8'(gerr));
      end
      $display("rates done");
   endtask : t_rates

   task automatic t_ferr;
      u_psp_peer.put(1'b0, 8'h81, 1'b1);
      tick(4);
      chk("err flag", 8'h1, 8'(gerr));
      chk("err byte", 8'h81, got);
      $display("frame error done");
   endtask : t_ferr

   task automatic t_prn;
      logic [7:0] d;
      bit ok;
      printer_mode_i = 1'b1;
      tick(2);
      chk("select", 8'h1, 8'(sync_device_select_o));
      fork
         send(1'b0, 8'h4e);
         u_psp_peer.get(1'b0, d, ok);
         begin
            tick(16);
            u_psp_peer.hs(1'b0);
         end
      join
      chk("finish byte", 8'h4e, d);
      send(1'b0, 8'hb1);
      u_psp_peer.get(1'b0, d, ok);
      chk("blocked", 8'h0, 8'(ok));
      fork
         u_psp_peer.get(1'b0, d, ok);
         u_psp_peer.hs(1'b1);
      join
      chk("released", 8'hb1, d);
      printer_mode_i = 1'b0;
      tick(2);
      $display("printer done");
   endtask : t_prn

   task automatic t_ring;
      ring_i = 1'b1;
      tick(120);
      chk("early wake", 8'h0, 8'(modem_wake_out_o));
      tick(10);
      chk("wake", 8'h1, 8'(modem_wake_out_o));
      chk("call mode", 8'h1, 8'(telecom_mode_o));
      ring_i = 1'b0;
      tick(2);
      telecom_end_i = 1'b1;
      tick(1);
      telecom_end_i = 1'b0;
      tick(2);
      chk("mode end", 8'h0, 8'(telecom_mode_o));
      rs232_ring_i = 1'b1;
      tick(2);
      rs232_ring_i = 1'b0;
      chk("rs232 call", 8'h1, 8'(telecom_mode_o));
      chk("no wake", 8'h0, 8'(modem_wake_out_o));
      telecom_end_i = 1'b1;
      tick(1);
      telecom_end_i = 1'b0;
      $display("ring done");
   endtask : t_ring

   task automatic t_sync;
      logic [7:0] d;
      logic pc;
      int k, n;
      k = 0;
      pc = 1'b0;
      d = 8'h00;
      sd_data_i = 8'hc5;
      sd_start_i = 1'b1;
      tick(1);
      sd_start_i = 1'b0;
      tick(1);
      chk("sd busy", 8'h1, 8'(sd_busy_o));
      chk("sd select", 8'h1, 8'(sync_device_select_o));
      for (n = 0; n < 5000 && sd_busy_o === 1'b1; n++)
      begin
         if (sync_clock_or_handshake_oe_o === 1'b1 && sync_clock_or_handshake_o === 1'b1 && !pc && k < 8)
         begin
            d[k] = txd_o;
            k++;
         end
         pc = sync_clock_or_handshake_o;
         tick(1);
      end
      chk("sd bits", 8'h8, 8'(k));
      chk("sd end", 8'h0, 8'(sd_busy_o));
      chk("sd data", 8'hc5, d);
      tick(300);
      $display("sync done");
   endtask : t_sync

   task automatic t_rs232;
      logic [7:0] d;
      bit ok;
      rs232_enable_i = 1'b1;
      tick(2);
      chk("dtr", 8'h1, 8'(rs232_dtr_o));
      chk("rts idle", 8'h0, 8'(rs232_rts_o));
      fork
         send(1'b1, 8'h6b);
         begin
            tick(6);
            chk("rts busy", 8'h1, 8'(rs232_rts_o));
         end
         u_psp_peer.get(1'b1, d, ok);
         u_psp_peer.put(1'b1, 8'hd2, 1'b0);
      join
      tick(2);
      chk("rs232 tx", 8'h6b, d);
      chk("rs232 rx", 8'hd2, rgot);
      $display("rs232 done");
   endtask : t_rs232

   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize

   initial
   begin
      tick(2);
      resetn_i = 1'b1;
      tick(1);
      chk("txd idle", 8'h0, 8'(txd_o));
      chk("rs232 idle", 8'h1, 8'(rs232_tx_o));
      t_rates;
      t_ferr;
      t_prn;
      t_ring;
      t_sync;
      t_rs232;
      summarize;
   end

   initial
   begin
      #700us;
      fails++;
      summarize;
   end
endmodule : tb_top
`default_nettype wire
